// ==== sfp_host_model.sv ====
// Behavioural serial host that frames instructions for the pin block
`timescale 1ns/1ps
module sfp_host_model (
  input wire logic [3:0] i_line, // Resolved data lines
  output logic o_sclk, // Serial clock, still outside frames
  output logic o_cs_n, // Select, active low
  output logic [3:0] o_d, // Host drive values
  output logic [3:0] o_oe // Host drive enables
);
  logic wp_n = 1'b1; // Protect level put on line 2

  // Start selected, so no falling select edge is seen after reset
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_d = 4'hF;
    o_oe = 4'hD;
  end

  // One frame: nbits out on line 0, then nrise read clocks over the given lanes
  task automatic frame(input logic [15:0] tx, input int nbits, input int nrise,
                       input int lanes, input bit mode3, input int pause_at,
                       output logic [7:0] rd);
    rd = 8'h00;
    o_sclk = mode3;
    o_d = {1'b1, wp_n, 2'b11};
    #4 o_cs_n = 1'b0;
    if (mode3) #3 o_sclk = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_d[0] = tx[15 - i];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    if (lanes > 1) o_oe[1:0] = 2'b00;
    if (lanes == 4) o_oe = 4'h0;
    for (int i = 0; i < nrise; i++) begin
      #3 o_sclk = 1'b1;
      rd = (lanes == 4) ? {rd[3:0], i_line} :
           (lanes == 2) ? {rd[5:0], i_line[1:0]} : {rd[6:0], i_line[1]};
      if (i == pause_at) o_d[3] = 1'b0;
      if (i == pause_at + 2) o_d[3] = 1'b1;
      #3 o_sclk = 1'b0;
    end
    #3 o_sclk = mode3;
    #3 o_cs_n = 1'b1;
    o_oe = 4'hD;
    #6;
  endtask : frame
endmodule : sfp_host_model

// ==== sfp_pin_sva.sv ====
// Port checker for the serial flash pin interface
`timescale 1ns/1ps
module sfp_pin_sva (
  input wire logic i_clk, // System clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic [31:0] o_prdata, // APB read data
  input wire logic o_pready, // APB ready
  input wire logic o_pslverr, // APB error
  input wire logic i_sclk, // Serial clock
  input wire logic i_cs_n, // Select, active low
  input wire logic i_data_line_3, // Line 3 in, pause
  input wire logic o_data_line_0, // Line 0 out
  input wire logic o_data_line_1, // Line 1 out
  input wire logic o_data_line_0_oe, // Line 0 enable
  input wire logic o_data_line_1_oe, // Line 1 enable
  input wire logic o_data_line_2_oe, // Line 2 enable
  input wire logic o_data_line_3_oe // Line 3 enable
);
  wire [3:0] oe_all = {o_data_line_3_oe, o_data_line_2_oe, o_data_line_1_oe, o_data_line_0_oe};
  logic [1:0] rise_snap;

  // Output lines as seen at each rising serial edge
  always_ff @(posedge i_sclk) begin
    rise_snap <= {o_data_line_1, o_data_line_0};
  end

  // ==========================================================================
  // Register bus answers
  ready_next_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_psel && !i_penable |=> o_pready) else $error("pready late");
  ready_pulse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_pready |-> i_psel && i_penable ##1 !o_pready) else $error("pready not single");
  err_clean_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_pslverr |-> o_pready && o_prdata == 32'h0000_0000) else $error("bad error answer");
  upper_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_pready) |-> o_prdata[31:9] == 23'h00_0000) else $error("upper bits set");

  // ==========================================================================
  // Link pins
  idle_float_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_cs_n [*2] |-> oe_all == 4'h0) else $error("line driven while deselected");
  lane_set_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    oe_all != 4'h0 |-> oe_all inside {4'h2, 4'h3, 4'hF}) else $error("bad lane set");
  rise_stable_a: assert property (@(negedge i_sclk) disable iff (i_cs_n || !i_reset_n)
    o_data_line_1_oe |-> {o_data_line_1, o_data_line_0} == rise_snap)
    else $error("output moved off falling edge");
  pause_float_a: assert property (@(negedge i_sclk) disable iff (i_cs_n || !i_reset_n)
    !i_data_line_3 && !o_data_line_3_oe |=> !o_data_line_1_oe && !o_data_line_0_oe)
    else $error("output driven while paused");
endmodule : sfp_pin_sva

bind sfp_serial_flash_pin sfp_pin_sva sfp_pin_sva_inst (.i_clk, .i_reset_n, .i_psel,
  .i_penable, .o_prdata, .o_pready, .o_pslverr, .i_sclk, .i_cs_n, .i_data_line_3,
  .o_data_line_0, .o_data_line_1, .o_data_line_0_oe, .o_data_line_1_oe,
  .o_data_line_2_oe, .o_data_line_3_oe);

// ==== sfp_pkg.sv ====
// Shared constants and types for the serial flash pin interface block
package sfp_pkg;

  // ==========================================================================
  // Register map, byte addresses on the APB side
  localparam logic [7:0] ADDR_SR1 = 8'h00;
  localparam logic [7:0] ADDR_SR2 = 8'h04;
  localparam logic [7:0] ADDR_FILL = 8'h08;
  localparam logic [7:0] ADDR_PROBE = 8'h0C;
  localparam logic [7:0] ADDR_INFO = 8'h10;

  // ==========================================================================
  // Status byte, info and probe field positions
  localparam int SR1_BUSY = 0;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_TB = 5;
  localparam int SR1_SEC = 6;
  localparam int SR1_SRP0 = 7;
  localparam int SR2_SRP1 = 0;
  localparam int SR2_QE = 1;
  localparam int SR2_CMP = 6;
  localparam int INFO_WP = 0;
  localparam int INFO_BUSY = 1;
  localparam int INFO_BLOCKED = 2;
  localparam int PROBE_HIT = 8;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] FILL_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Serial instruction codes
  localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
  localparam logic [7:0] OP_READ_SR1 = 8'h05;
  localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
  localparam logic [7:0] OP_READ_SR2 = 8'h35;
  localparam logic [7:0] OP_READ_DUAL = 8'h3B;
  localparam logic [7:0] OP_READ_QUAD = 8'h6B;

  // ==========================================================================
  // Bits moved per serial clock, and the enable pattern of each width
  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [2:0] STEP_TWO = 3'h2;
  localparam logic [2:0] STEP_FOUR = 3'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] OE_ONE = 4'h2;
  localparam logic [3:0] OE_TWO = 4'h3;
  localparam logic [3:0] OE_FOUR = 4'hF;

  // ==========================================================================
  // Protection geometry, in 4 KB sectors
  localparam int SECTOR_COUNT = 256;
  localparam int BLOCK_SECTORS = 16;
  localparam int SMALL_MAX_SHIFT = 3;

  // ==========================================================================
  // Timing of an internal status write cycle
  localparam int WRITE_TIME_NS = 10000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS * 1000) / CLK_PERIOD_PS;

  // ==========================================================================
  // Link states and read sources
  typedef enum logic [3:0] {
    L_CMD = 4'b0001,
    L_WRS = 4'b0010,
    L_SEND = 4'b0100,
    L_IGN = 4'b1000
  } sfp_lstate_t;

  typedef enum logic [1:0] {
    SRC_SR1 = 2'h0,
    SRC_SR2 = 2'h1,
    SRC_FILL = 2'h2
  } sfp_src_t;

endpackage : sfp_pkg

// ==== sfp_serial_flash_pin.sv ====
// Serial flash pin interface: link shifter, status bytes, write protection, APB slave
`timescale 1ns/1ps
//
// Function
// - Deselected device floats all data lines
// - Started status write finishes despite deselect
// - Select low accepts instructions, returns data
// - First instruction needs prior select falling edge
// - Single mode samples serial input rising
// - Single mode drives output on falling
// - Dual/quad lines bidirectional, rise in, fall out
// - Standard/dual use lines 0-1, quad 0-3
// - Quad instructions need quad enable bit
// - Quad enable turns write-protect/pause into lines 2/3
// - Active-low write-protect blocks status writes
// - Protection combines pin with guard bits
// - Quad enable disables write-protect function
// - Pause floats output, ignores clock and input
// - Clock modes 0 and 3 supported
module sfp_serial_flash_pin #(
  parameter int WRITE_CYCLES_P = sfp_pkg::WRITE_CYCLES
) (
  input wire logic i_clk, // System clock, 200 MHz
  input wire logic i_reset_n, // Asynchronous reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction, high for write
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  input wire logic i_sclk, // Serial clock from the host
  input wire logic i_cs_n, // Select, active low
  input wire logic i_data_line_0, // Line 0 in, serial input pin
  input wire logic i_data_line_1, // Line 1 in
  input wire logic i_data_line_2, // Line 2 in, write-protect when quad off
  input wire logic i_data_line_3, // Line 3 in, pause when quad off
  output logic o_data_line_0, // Line 0 out
  output logic o_data_line_1, // Line 1 out, serial output pin
  output logic o_data_line_2, // Line 2 out
  output logic o_data_line_3, // Line 3 out
  output logic o_data_line_0_oe, // Line 0 drive enable
  output logic o_data_line_1_oe, // Line 1 drive enable
  output logic o_data_line_2_oe, // Line 2 drive enable
  output logic o_data_line_3_oe // Line 3 drive enable
);
  import sfp_pkg::*;

  // ==========================================================================
  // State records
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] fill;
    logic [7:0] probe;
    logic blocked;
    logic wp_m;
    logic wp_s;
    logic tog_m;
    logic tog_s;
    logic tog_d;
    logic [15:0] cnt;
    logic pend_sel;
    logic [7:0] pend_byte;
  } sfp_core_t;

  typedef struct packed {
    sfp_lstate_t state;
    logic [2:0] bcnt;
    logic [7:0] sh;
    logic [2:0] step;
    sfp_src_t src;
    logic sel;
  } sfp_link_t;

  typedef struct packed {
    logic [7:0] sr1_m;
    logic [7:0] sr1_s;
    logic [7:0] sr2_m;
    logic [7:0] sr2_s;
    logic [7:0] fill_m;
    logic [7:0] fill_s;
    logic tog;
    logic sel;
    logic [7:0] wbyte;
  } sfp_req_t;

  typedef struct packed {
    logic hold;
    logic [7:0] osh;
    logic [2:0] ocnt;
    logic [3:0] dout;
    logic [3:0] oe;
  } sfp_out_t;

  sfp_core_t c_reg;
  sfp_core_t c_next;
  sfp_link_t l_reg;
  sfp_link_t l_next;
  sfp_req_t q_reg;
  sfp_req_t q_next;
  sfp_out_t n_reg;
  sfp_out_t n_next;
  logic armed_reg;
  logic link_rst_n;
  logic lock_now;
  logic probe_hit;
  logic qe_link;
  logic [7:0] op_in;
  logic [7:0] cur_byte;
  logic [7:0] src_byte;

  // Protection test for one sector against the guard bits
  function automatic logic sector_guarded(input logic [7:0] sector, input logic [7:0] s1,
                                          input logic [7:0] s2);
    logic [2:0] bp;
    logic [8:0] span;
    logic in_span;
    bp = s1[SR1_BP_LO +: 3];
    span = 9'h000;
    if (bp != 3'h0) begin
      if (s1[SR1_SEC]) begin
        span = (bp > 3'(SMALL_MAX_SHIFT + 1)) ? 9'(1 << SMALL_MAX_SHIFT) : 9'(1 << (bp - 3'h1));
      end else begin
        // Cap at full width, so a large guard value cannot wrap the span to zero
        span = ((BLOCK_SECTORS << (bp - 3'h1)) > SECTOR_COUNT) ? 9'(SECTOR_COUNT) :
               9'(BLOCK_SECTORS << (bp - 3'h1));
      end
    end
    if (s1[SR1_TB]) begin
      in_span = {1'b0, sector} < span;
    end else begin
      in_span = {1'b0, sector} >= (9'(SECTOR_COUNT) - span);
    end
    return in_span ^ s2[SR2_CMP];
  endfunction : sector_guarded

  // ==========================================================================
  // Core domain: APB slave, status bytes, internal write cycle
  assign lock_now = c_reg.sr2[SR2_SRP1] | (c_reg.sr1[SR1_SRP0] & ~c_reg.wp_s &
                    ~c_reg.sr2[SR2_QE]);
  assign probe_hit = sector_guarded(c_reg.probe, c_reg.sr1, c_reg.sr2);

  // Next state of the core domain
  always_comb begin
    c_next = c_reg;
    c_next.wp_m = i_data_line_2;
    c_next.wp_s = c_reg.wp_m;
    c_next.tog_m = q_reg.tog;
    c_next.tog_s = c_reg.tog_m;
    c_next.tog_d = c_reg.tog_s;
    c_next.pready = i_psel & ~i_penable;
    c_next.pslverr = 1'b0;
    // Read data and error are prepared in the setup cycle
    if (i_psel & ~i_penable) begin
      c_next.prdata = WORD_ZERO;
      case (i_paddr)
        ADDR_SR1: c_next.prdata[7:0] = c_reg.sr1;
        ADDR_SR2: c_next.prdata[7:0] = c_reg.sr2;
        ADDR_FILL: c_next.prdata[7:0] = c_reg.fill;
        ADDR_PROBE: begin
          c_next.prdata[7:0] = c_reg.probe;
          c_next.prdata[PROBE_HIT] = probe_hit;
        end
        ADDR_INFO: begin
          c_next.prdata[INFO_WP] = c_reg.wp_s;
          c_next.prdata[INFO_BUSY] = c_reg.sr1[SR1_BUSY];
          c_next.prdata[INFO_BLOCKED] = c_reg.blocked;
        end
        default: c_next.pslverr = 1'b1;
      endcase
    end
    // Writes take effect at the completing edge
    if (i_psel & i_penable & c_reg.pready & i_pwrite) begin
      case (i_paddr)
        ADDR_SR1: c_next.sr1 = {i_pwdata[7:1], c_reg.sr1[SR1_BUSY]};
        ADDR_SR2: c_next.sr2 = i_pwdata[7:0];
        ADDR_FILL: c_next.fill = i_pwdata[7:0];
        ADDR_PROBE: c_next.probe = i_pwdata[7:0];
        ADDR_INFO: begin
          if (i_pwdata[INFO_BLOCKED]) begin
            c_next.blocked = 1'b0;
          end
        end
        default: c_next.blocked = c_reg.blocked;
      endcase
    end
    // Host status write request arrives as a toggle
    if ((c_reg.tog_s != c_reg.tog_d) && !c_reg.sr1[SR1_BUSY]) begin
      if (lock_now) begin
        c_next.blocked = 1'b1;
      end else begin
        c_next.sr1[SR1_BUSY] = 1'b1;
        c_next.cnt = 16'(WRITE_CYCLES_P - 1);
        c_next.pend_sel = q_reg.sel;
        c_next.pend_byte = q_reg.wbyte;
      end
    end
    // Write cycle runs to its end whatever the select does
    if (c_reg.sr1[SR1_BUSY]) begin
      if (c_reg.cnt == 16'h0000) begin
        c_next.sr1[SR1_BUSY] = 1'b0;
        if (c_reg.pend_sel) begin
          c_next.sr2 = c_reg.pend_byte;
        end else begin
          c_next.sr1 = {c_reg.pend_byte[7:1], 1'b0};
        end
      end else begin
        c_next.cnt = c_reg.cnt - 16'h0001;
      end
    end
  end

  // Core domain register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      c_reg <= '{pready: 1'b0, pslverr: 1'b0, prdata: WORD_ZERO, sr1: SR1_RESET,
                 sr2: SR2_RESET, fill: FILL_RESET, probe: 8'h00, blocked: 1'b0,
                 wp_m: 1'b1, wp_s: 1'b1, tog_m: 1'b0, tog_s: 1'b0, tog_d: 1'b0,
                 cnt: 16'h0000, pend_sel: 1'b0, pend_byte: 8'h00};
    end else begin
      c_reg <= c_next;
    end
  end

  assign o_prdata = c_reg.prdata;
  assign o_pready = c_reg.pready;
  assign o_pslverr = c_reg.pslverr;

  // ==========================================================================
  // Link domain: select acts as the link reset
  assign link_rst_n = i_reset_n & ~i_cs_n;

  // Armed once a select falling edge is seen after reset
  always_ff @(negedge i_cs_n or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  assign qe_link = q_reg.sr2_s[SR2_QE];
  assign op_in = {l_reg.sh[6:0], i_data_line_0};

  // Rising edge shifter and instruction decode
  always_comb begin
    l_next = l_reg;
    if (!n_reg.hold) begin
      l_next.sh = op_in;
      l_next.bcnt = 3'(l_reg.bcnt + 3'h1);
      case (l_reg.state)
        L_CMD: begin
          if (l_reg.bcnt == BIT_LAST) begin
            l_next.state = L_IGN;
            if (armed_reg) begin
              case (op_in)
                OP_READ_SR1: begin
                  l_next.state = L_SEND;
                  l_next.src = SRC_SR1;
                  l_next.step = STEP_ONE;
                end
                OP_READ_SR2: begin
                  l_next.state = L_SEND;
                  l_next.src = SRC_SR2;
                  l_next.step = STEP_ONE;
                end
                OP_WRITE_SR1: begin
                  l_next.state = L_WRS;
                  l_next.sel = 1'b0;
                end
                OP_WRITE_SR2: begin
                  l_next.state = L_WRS;
                  l_next.sel = 1'b1;
                end
                OP_READ_DUAL: begin
                  l_next.state = L_SEND;
                  l_next.src = SRC_FILL;
                  l_next.step = STEP_TWO;
                end
                OP_READ_QUAD: begin
                  if (qe_link) begin
                    l_next.state = L_SEND;
                    l_next.src = SRC_FILL;
                    l_next.step = STEP_FOUR;
                  end
                end
                default: l_next.state = L_IGN;
              endcase
            end
          end
        end
        L_WRS: begin
          if (l_reg.bcnt == BIT_LAST) begin
            l_next.state = L_IGN;
          end
        end
        L_SEND: l_next.state = L_SEND;
        L_IGN: l_next.state = L_IGN;
        default: l_next.state = L_IGN;
      endcase
    end
  end

  // Link shifter register, cleared while deselected
  always_ff @(posedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_reg <= '{state: L_CMD, bcnt: 3'h0, sh: 8'h00, step: STEP_ONE, src: SRC_SR1,
                 sel: 1'b0};
    end else begin
      l_reg <= l_next;
    end
  end

  // Status view synchronisers and the write request handshake
  always_comb begin
    q_next = q_reg;
    q_next.sr1_m = c_reg.sr1;
    q_next.sr1_s = q_reg.sr1_m;
    q_next.sr2_m = c_reg.sr2;
    q_next.sr2_s = q_reg.sr2_m;
    q_next.fill_m = c_reg.fill;
    q_next.fill_s = q_reg.fill_m;
    if (!i_cs_n && !n_reg.hold && (l_reg.state == L_WRS) && (l_reg.bcnt == BIT_LAST)) begin
      q_next.tog = ~q_reg.tog;
      q_next.sel = l_reg.sel;
      q_next.wbyte = op_in;
    end
  end

  // Request and view registers survive deselect
  always_ff @(posedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q_reg <= '{sr1_m: SR1_RESET, sr1_s: SR1_RESET, sr2_m: SR2_RESET, sr2_s: SR2_RESET,
                 fill_m: FILL_RESET, fill_s: FILL_RESET, tog: 1'b0, sel: 1'b0,
                 wbyte: 8'h00};
    end else begin
      q_reg <= q_next;
    end
  end

  // Byte returned to the host
  always_comb begin
    case (l_reg.src)
      SRC_SR1: src_byte = q_reg.sr1_s;
      SRC_SR2: src_byte = q_reg.sr2_s;
      SRC_FILL: src_byte = q_reg.fill_s;
      default: src_byte = q_reg.fill_s;
    endcase
  end

  // Falling edge output stage, pause capture and line drive
  always_comb begin
    n_next = n_reg;
    cur_byte = (n_reg.ocnt == 3'h0) ? src_byte : n_reg.osh;
    n_next.hold = ~i_data_line_3 & ~qe_link;
    if (n_next.hold) begin
      n_next.oe = 4'h0;
    end else if (l_reg.state == L_SEND) begin
      n_next.osh = cur_byte << l_reg.step;
      n_next.ocnt = 3'(n_reg.ocnt + l_reg.step);
      case (l_reg.step)
        STEP_FOUR: begin
          n_next.dout = cur_byte[7:4];
          n_next.oe = OE_FOUR;
        end
        STEP_TWO: begin
          n_next.dout = {2'b00, cur_byte[7:6]};
          n_next.oe = OE_TWO;
        end
        default: begin
          n_next.dout = {2'b00, cur_byte[7], 1'b0};
          n_next.oe = OE_ONE;
        end
      endcase
    end else begin
      n_next.oe = 4'h0;
    end
  end

  // Output register on the falling edge; mode 3 first edge finds idle state
  always_ff @(negedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      n_reg <= '{hold: 1'b0, osh: 8'h00, ocnt: 3'h0, dout: 4'h0, oe: 4'h0};
    end else begin
      n_reg <= n_next;
    end
  end

  assign o_data_line_0 = n_reg.dout[0];
  assign o_data_line_1 = n_reg.dout[1];
  assign o_data_line_2 = n_reg.dout[2];
  assign o_data_line_3 = n_reg.dout[3];
  assign o_data_line_0_oe = n_reg.oe[0];
  assign o_data_line_1_oe = n_reg.oe[1];
  assign o_data_line_2_oe = n_reg.oe[2];
  assign o_data_line_3_oe = n_reg.oe[3];

endmodule : sfp_serial_flash_pin

// ==== sfp_serial_flash_pin_test.sv ====
// Self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sfp_serial_flash_pin_test;
  import sfp_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, oe_seen, flt = 1'b0;
  logic [7:0] s1, s2, sec, f, rv;
  wire [3:0] dout, doe, hd, hoe, line;
  wire sclk, cs_n;
  int seed = 32'h3428_6235;
  int err_total = 0;
  int tests_run = 0;

  // Wire levels: device, then host, else a pattern that flips every clock
  assign line = (doe & dout) | (~doe & hoe & hd) | (~doe & ~hoe & {4{flt}});
  always @(posedge i_clk) flt <= ~flt;
  always @(doe) if (|doe) oe_seen = 1'b1;
  initial forever #2.5 i_clk = ~i_clk;
  initial begin
    #200000;
    err_total++;
    test_done();
  end

  sfp_serial_flash_pin #(.WRITE_CYCLES_P(8)) sfp_serial_flash_pin_inst (.i_clk, .i_reset_n,
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_data_line_0(line[0]), .i_data_line_1(line[1]), .i_data_line_2(line[2]),
    .i_data_line_3(line[3]), .o_data_line_0(dout[0]), .o_data_line_1(dout[1]),
    .o_data_line_2(dout[2]), .o_data_line_3(dout[3]), .o_data_line_0_oe(doe[0]),
    .o_data_line_1_oe(doe[1]), .o_data_line_2_oe(doe[2]), .o_data_line_3_oe(doe[3]));
  sfp_host_model sfp_host_model_inst (.i_line(line), .o_sclk(sclk), .o_cs_n(cs_n), .o_d(hd),
    .o_oe(hoe));

  // ==========================================================================
  // Bus, link and expectation helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      test_done();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdreg(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, WORD_ZERO);
    `CHK(rdata, {24'h00_0000, e})
  endtask : rdreg

  task automatic lframe(input logic [15:0] tx, input int nb, input int lanes, input bit m3);
    sfp_host_model_inst.frame(tx, nb, (nb == 8) ? 16 / lanes : 0, lanes, m3, -1, rv);
  endtask : lframe

  task automatic lread(input logic [7:0] op, input int lanes, input bit m3, input logic [7:0] e);
    lframe({8'h00, 8'h00}, 8, 1, 1'b0);
    lframe({op, 8'h00}, 8, lanes, m3);
    `CHK(rv, e)
  endtask : lread

  task automatic lwrite(input logic [7:0] v, input int nb);
    int n;
    n = 0;
    lframe({8'h00, 8'h00}, 8, 1, 1'b0);
    lframe({OP_WRITE_SR1, v}, nb, 1, 1'b0);
    repeat (4) @(posedge i_clk);
    do begin
      apb(1'b0, ADDR_SR1, WORD_ZERO);
      n++;
    end while (rdata[SR1_BUSY] !== 1'b0 && n < 40);
    if (rdata[SR1_BUSY] !== 1'b0) begin
      err_total++;
      test_done();
    end
  endtask : lwrite

  function automatic logic prot(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
    int g;
    int n;
    logic p;
    g = a[4:2];
    n = (g == 0) ? 0 : a[SR1_SEC] ? 1 << ((g > 4 ? 4 : g) - 1) : 16 << (g - 1);
    if (n > SECTOR_COUNT) n = SECTOR_COUNT;
    p = a[SR1_TB] ? (int'(s) < n) : (int'(s) >= SECTOR_COUNT - n);
    return b[SR2_CMP] ? !p : p;
  endfunction : prot

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    oe_seen = 1'b0;
    lframe({OP_READ_SR1, 8'h00}, 8, 1, 1'b0);
    `CHK(oe_seen, 1'b0)
    rdreg(ADDR_SR1, SR1_RESET);
    rdreg(ADDR_SR2, SR2_RESET);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    `CHK(rerr, 1'b1)
    rdreg(8'h14, 8'h00);
    `CHK(rerr, 1'b1)
    // Random status and fill bytes through every read width
    for (int k = 0; k < 4; k++) begin
      s1 = $random(seed) & 8'h7C;
      f = $random(seed);
      apb(1'b1, ADDR_SR1, {24'h00_0000, s1});
      apb(1'b1, ADDR_FILL, {24'h00_0000, f});
      apb(1'b1, ADDR_SR2, WORD_ZERO);
      lread(OP_READ_SR1, 1, k[0], s1);
      lread(OP_READ_SR2, 1, 1'b0, 8'h00);
      lread(OP_READ_DUAL, 2, k[0], f);
      oe_seen = 1'b0;
      lframe({OP_READ_QUAD, 8'h00}, 8, 4, 1'b0);
      `CHK(oe_seen, 1'b0)
      apb(1'b1, ADDR_SR2, 32'h0000_0002);
      lread(OP_READ_QUAD, 4, 1'b0, f);
    end
    // Locked status write against the protect pin and the quad enable bit
    apb(1'b1, ADDR_SR2, WORD_ZERO);
    apb(1'b1, ADDR_SR1, 32'h0000_0080);
    sfp_host_model_inst.wp_n = 1'b0;
    lwrite(8'h1C, 16);
    rdreg(ADDR_SR1, 8'h80);
    rdreg(ADDR_INFO, 8'h04);
    apb(1'b1, ADDR_INFO, 32'h0000_0004);
    rdreg(ADDR_INFO, 8'h00);
    sfp_host_model_inst.wp_n = 1'b1;
    lwrite(8'h9C, 16);
    rdreg(ADDR_SR1, 8'h9C);
    apb(1'b1, ADDR_SR2, 32'h0000_0002);
    sfp_host_model_inst.wp_n = 1'b0;
    lwrite(8'h88, 16);
    rdreg(ADDR_SR1, 8'h88);
    lwrite(8'h00, 12);
    rdreg(ADDR_SR1, 8'h88);
    lread(OP_READ_SR1, 1, 1'b0, 8'h88);
    // Pause in mid-read, then a clean read
    apb(1'b1, ADDR_SR2, WORD_ZERO);
    sfp_host_model_inst.wp_n = 1'b1;
    sfp_host_model_inst.frame({OP_READ_SR1, 8'h00}, 8, 16, 1, 1'b0, 4, rv);
    `CHK(rv, 8'h22)
    lread(OP_READ_SR1, 1, 1'b1, 8'h88);
    // Protected region for random guard settings and sectors
    for (int k = 0; k < 24; k++) begin
      s1 = $random(seed) & 8'h7C;
      s2 = $random(seed) & 8'h40;
      sec = $random(seed);
      apb(1'b1, ADDR_SR1, {24'h00_0000, s1});
      apb(1'b1, ADDR_SR2, {24'h00_0000, s2});
      apb(1'b1, ADDR_PROBE, {24'h00_0000, sec});
      apb(1'b0, ADDR_PROBE, WORD_ZERO);
      `CHK(rdata[PROBE_HIT], prot(s1, s2, sec))
    end
    test_done();
  end
endmodule : sfp_serial_flash_pin_test
